// *** src/dfcsw_defines.svh ***
// bit positions and constants of the fieldbus command and state words
`ifndef DFCSW_DEFINES_SVH
`define DFCSW_DEFINES_SVH
`define DFCSW_CMD_RAMP_STOP 4'h0
`define DFCSW_CMD_COAST_STOP 4'h1
`define DFCSW_CMD_QUICK_STOP 4'h2
`define DFCSW_CMD_RUN 4'h3
`define DFCSW_CMD_RAMP_OUT_ZERO 4'h4
`define DFCSW_CMD_RAMP_HOLD 4'h5
`define DFCSW_CMD_RAMP_IN_ZERO 4'h6
`define DFCSW_CMD_FAULT_RESET 4'h7
`define DFCSW_CMD_JOG_A 4'h8
`define DFCSW_CMD_JOG_B 4'h9
`define DFCSW_CMD_REMOTE 4'hA
`define DFCSW_CMD_LOCATION 4'hB
`define DFCSW_STOP_MASK 16'h0007
`define DFCSW_CMD_RESET 16'h0000
`define DFCSW_STATE_RESET 16'h0000
`define DFCSW_SEL_W 3
`endif

// *** src/dfcsw_interp.sv ***
// fieldbus command word decoder, drive state sequencer and state word
`include "dfcsw_defines.svh"
`default_nettype none
module dfcsw_interp
  import dfcsw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] fieldbus_command_word,
  input wire logic command_valid,
  input wire dfcsw_drive_s drive_in,
  input wire logic [15:0] user_signals,
  input wire logic [`DFCSW_SEL_W*4-1:0] user_select,
  output dfcsw_req_s req_out,
  output logic fault_clear,
  output logic [15:0] fieldbus_state_word
);
  dfcsw_state_e state_reg, state_next;
  logic [15:0] cmd_reg, cmd_next;
  logic reset_bit_reg, reset_bit_next;
  logic fault_clear_reg, fault_clear_next;
  dfcsw_req_s req_reg, req_next;
  logic [15:0] word_reg, word_next;
  logic [15:0] eff;
  logic ramp_stop_n, coast_stop_n, quick_stop_n, reset_edge;

  always_comb
  begin
    cmd_next = command_valid ? fieldbus_command_word : cmd_reg;
    // remote bit low: only the stop bits get through
    if (cmd_reg[`DFCSW_CMD_REMOTE])
      eff = cmd_reg;
    else
      eff = cmd_reg & `DFCSW_STOP_MASK;
    ramp_stop_n = eff[`DFCSW_CMD_RAMP_STOP];
    coast_stop_n = eff[`DFCSW_CMD_COAST_STOP];
    quick_stop_n = eff[`DFCSW_CMD_QUICK_STOP];
    reset_bit_next = eff[`DFCSW_CMD_FAULT_RESET];
    reset_edge = eff[`DFCSW_CMD_FAULT_RESET] & ~reset_bit_reg
      & drive_in.reset_from_bus;
    fault_clear_next = reset_edge & drive_in.fault_active;
  end

  always_comb
  begin
    state_next = state_reg;
    if (drive_in.fault_active && !reset_edge)
      state_next = DFCSW_FAULT;
    else
      case (state_reg)
        DFCSW_FAULT:
          if (reset_edge)
            state_next = DFCSW_INHIBITED;
        DFCSW_NOT_READY:
          if (drive_in.power_ready)
            state_next = DFCSW_INHIBITED;
        DFCSW_INHIBITED:
          if (coast_stop_n && quick_stop_n && !ramp_stop_n)
            state_next = DFCSW_READY_ON;
        DFCSW_READY_ON:
          if (!coast_stop_n || !quick_stop_n)
            state_next = DFCSW_INHIBITED;
          else if (ramp_stop_n)
            state_next = DFCSW_READY_OP;
        DFCSW_READY_OP:
          if (!coast_stop_n || !quick_stop_n)
            state_next = DFCSW_INHIBITED;
          else if (!ramp_stop_n)
            state_next = DFCSW_READY_ON;
          else if (eff[`DFCSW_CMD_RUN] && drive_in.run_enable)
            state_next = DFCSW_ENABLED;
        DFCSW_ENABLED:
          if (!coast_stop_n)
            state_next = DFCSW_INHIBITED;
          else if (!quick_stop_n || !ramp_stop_n)
            state_next = DFCSW_STOPPING;
          else if (!eff[`DFCSW_CMD_RUN] || !drive_in.run_enable)
            state_next = DFCSW_READY_OP;
        DFCSW_STOPPING:
          if (!coast_stop_n || !quick_stop_n)
          begin
            if (drive_in.stop_done || !coast_stop_n)
              state_next = DFCSW_INHIBITED;
          end
          else if (drive_in.stop_done)
          begin
            if (drive_in.stop_interlock)
              state_next = DFCSW_INHIBITED;
            else
              state_next = DFCSW_READY_ON;
          end
        default:
          state_next = DFCSW_NOT_READY;
      endcase
  end

  always_comb
  begin
    req_next.ramp_stop = ~ramp_stop_n;
    req_next.coast_stop = ~coast_stop_n;
    req_next.quick_stop = ~quick_stop_n;
    req_next.run = state_next == DFCSW_ENABLED;
    req_next.ramp_out_zero = ~eff[`DFCSW_CMD_RAMP_OUT_ZERO];
    req_next.ramp_hold = ~eff[`DFCSW_CMD_RAMP_HOLD];
    req_next.ramp_in_zero = ~eff[`DFCSW_CMD_RAMP_IN_ZERO];
    req_next.jog_a = eff[`DFCSW_CMD_JOG_A];
    req_next.jog_b = eff[`DFCSW_CMD_JOG_B];
    req_next.location_b = drive_in.location_from_bus
      & eff[`DFCSW_CMD_LOCATION];
  end

  always_comb
  begin
    word_next = `DFCSW_STATE_RESET;
    word_next[0] = state_reg == DFCSW_READY_ON
      || state_reg == DFCSW_READY_OP
      || state_reg == DFCSW_ENABLED;
    word_next[1] = state_reg == DFCSW_READY_OP
      || state_reg == DFCSW_ENABLED;
    word_next[2] = state_reg == DFCSW_ENABLED;
    word_next[3] = state_reg == DFCSW_FAULT;
    word_next[4] = coast_stop_n;
    word_next[5] = quick_stop_n;
    word_next[6] = state_reg == DFCSW_INHIBITED;
    word_next[7] = drive_in.warning;
    word_next[8] = drive_in.setpoint_reached;
    word_next[9] = drive_in.remote;
    word_next[10] = drive_in.above_limit;
    for (int i = 0; i < 4; i++)
      word_next[11 + i] =
        user_signals[user_select[i*`DFCSW_SEL_W +: `DFCSW_SEL_W]];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= DFCSW_NOT_READY;
      cmd_reg <= `DFCSW_CMD_RESET;
      reset_bit_reg <= 1'b0;
      fault_clear_reg <= 1'b0;
      req_reg <= '0;
      word_reg <= `DFCSW_STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      reset_bit_reg <= reset_bit_next;
      fault_clear_reg <= fault_clear_next;
      req_reg <= req_next;
      word_reg <= word_next;
    end
  end

  assign req_out = req_reg;
  assign fault_clear = fault_clear_reg;
  assign fieldbus_state_word = word_reg;
endmodule : dfcsw_interp
`default_nettype wire

// *** src/dfcsw_pkg.sv ***
// types of the fieldbus command interpreter
`default_nettype none
package dfcsw_pkg;
  typedef enum logic [6:0] {
    DFCSW_NOT_READY = 7'h01,
    DFCSW_INHIBITED = 7'h02,
    DFCSW_READY_ON = 7'h04,
    DFCSW_READY_OP = 7'h08,
    DFCSW_ENABLED = 7'h10,
    DFCSW_STOPPING = 7'h20,
    DFCSW_FAULT = 7'h40
  } dfcsw_state_e;

  typedef struct packed {
    logic ramp_stop;
    logic coast_stop;
    logic quick_stop;
    logic run;
    logic ramp_out_zero;
    logic ramp_hold;
    logic ramp_in_zero;
    logic jog_a;
    logic jog_b;
    logic location_b;
  } dfcsw_req_s;

  typedef struct packed {
    logic reset_from_bus;
    logic location_from_bus;
    logic run_enable;
    logic stop_interlock;
    logic power_ready;
    logic fault_active;
    logic warning;
    logic setpoint_reached;
    logic remote;
    logic above_limit;
    logic stop_done;
  } dfcsw_drive_s;
endpackage : dfcsw_pkg
`default_nettype wire

// *** tb/dfcsw_interp_monitor.sv ***
// assertions on the command interpreter ports
`include "dfcsw_defines.svh"
`default_nettype none
module dfcsw_monitor
  import dfcsw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] fieldbus_command_word,
  input wire logic command_valid,
  input wire dfcsw_drive_s drive_in,
  input wire logic [15:0] user_signals,
  input wire logic [`DFCSW_SEL_W*4-1:0] user_select,
  input wire dfcsw_req_s req_out,
  input wire logic fault_clear,
  input wire logic [15:0] fieldbus_state_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence cmd_taken;
    command_valid ##2 1'b1;
  endsequence
  sequence local_taken;
    command_valid && !fieldbus_command_word[10] ##2 1'b1;
  endsequence
  stop_request_a: assert property (cmd_taken |->
    {req_out.ramp_stop, req_out.coast_stop, req_out.quick_stop}
    == ~$past({fieldbus_command_word[0], fieldbus_command_word[1],
    fieldbus_command_word[2]}, 2)) else $error("stop request wrong");
  local_gate_a: assert property (local_taken |->
    !req_out.run && !req_out.jog_a && !req_out.jog_b)
    else $error("local word not ignored");
  ramp_input_a: assert property (cmd_taken |->
    req_out.ramp_in_zero == !$past(fieldbus_command_word[6]
    && fieldbus_command_word[10], 2)) else $error("ramp input wrong");
  jog_request_a: assert property (cmd_taken |->
    {req_out.jog_a, req_out.jog_b} == $past(fieldbus_command_word[9:8]
    & {2{fieldbus_command_word[10]}}, 2)) else $error("jog wrong");
  clear_pulse_a: assert property (fault_clear |=> !fault_clear)
    else $error("fault clear too long");
  clear_source_a: assert property (!drive_in.reset_from_bus [*3]
    |-> !fault_clear) else $error("fault clear without source");
  status_mirror_a: assert property (
    !$past(rst) |-> fieldbus_state_word[10:7] == $past({drive_in.above_limit,
    drive_in.remote, drive_in.setpoint_reached, drive_in.warning}))
    else $error("state bits 7 to 10 wrong");
  user_bit_a: assert property (!$past(rst) |->
    fieldbus_state_word[11] == $past(user_signals[user_select[2:0]]))
    else $error("user bit wrong");
  reserved_bit_a: assert property (!fieldbus_state_word[15])
    else $error("reserved bit set");
endmodule : dfcsw_monitor
bind dfcsw_interp dfcsw_monitor u_mon (.clock(clock), .rst(rst),
  .fieldbus_command_word(fieldbus_command_word),
  .command_valid(command_valid), .drive_in(drive_in),
  .user_signals(user_signals), .user_select(user_select),
  .req_out(req_out), .fault_clear(fault_clear),
  .fieldbus_state_word(fieldbus_state_word));
`default_nettype wire

// *** tb/dfcsw_master.sv ***
// fieldbus master model issuing command words
`default_nettype none
module dfcsw_master
(
  input wire logic clock,
  output logic [15:0] word,
  output logic valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    word = 16'h0000;
    valid = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    word <= (w[9:8] != 2'h0) ? (w & 16'hFF8F) : w;
    valid <= 1'b1;
    @(posedge clock);
    valid <= 1'b0;
    word <= ~word;
    @(posedge clock);
  endtask : send
endmodule : dfcsw_master
`default_nettype wire

// *** tb/test_drive_fieldbus_command_status_word.sv ***
// testbench of the fieldbus command interpreter
`include "dfcsw_defines.svh"
`default_nettype none
module test_drive_fieldbus_command_status_word;
  import dfcsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] cmd;
  logic valid;
  dfcsw_drive_s drv = 11'h357;
  logic [15:0] usr = 16'h00A5;
  logic [`DFCSW_SEL_W*4-1:0] sel = 12'hF4A;
  dfcsw_req_s req;
  logic fclr;
  logic got_clr = 1'b0;
  logic [15:0] sw;
  logic [15:0] stops [3] = '{16'h040D, 16'h040B, 16'h040E};
  logic [3:0] stop_exp [3] = '{4'hC, 4'hA, 4'h7};
  int n_fail = 0;
  int n_checks = 0;
  always #4 clock = ~clock;
  always @(posedge clock) if (fclr === 1'b1) got_clr <= 1'b1;
  dfcsw_master u_master (.clock(clock), .word(cmd), .valid(valid));
  dfcsw_interp u_dut (.clock(clock), .rst(rst),
    .fieldbus_command_word(cmd), .command_valid(valid), .drive_in(drv),
    .user_signals(usr), .user_select(sel), .req_out(req),
    .fault_clear(fclr), .fieldbus_state_word(sw));
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic go(input logic [15:0] w, input int n);
    u_master.send(w);
    repeat (n) @(posedge clock);
  endtask : go
  initial
  begin
    #20000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check("inhibited", sw[6:0], 7'h40);
    check("upper state", sw[15:7], 9'h0DD);
    go(16'h0406, 3);
    check("ready on", sw[6:0], 7'h31);
    go(16'h040F, 4);
    check("enabled", {sw[2], req.run}, 2'h3);
    go(16'h000F, 1);
    check("local run", req.run, 1'b0);
    go(16'h0770, 1);
    check("jog", {req.jog_a, req.jog_b, req.ramp_in_zero}, 3'h7);
    go(16'h0C0F, 1);
    check("location", req.location_b, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      go(16'h0406, 3);
      go(16'h040F, 4);
      go(stops[i], 6);
      check("stop", {sw[6:4], sw[0]}, stop_exp[i]);
    end
    drv.fault_active <= 1'b1;
    go(16'h0406, 3);
    go(16'h0486, 4);
    check("fault kept", {sw[3], got_clr}, 2'h2);
    drv.reset_from_bus <= 1'b1;
    go(16'h0406, 1);
    // stop bits low so the cleared drive stays switch-on inhibited
    go(16'h0480, 0);
    // fault goes away once the clear edge has been taken
    drv.fault_active <= 1'b0;
    repeat (4) @(posedge clock);
    check("fault cleared", {sw[6], sw[3], got_clr}, 3'h5);
    stop_test();
  end
endmodule : test_drive_fieldbus_command_status_word
`default_nettype wire
